/* cap2_pm_assertions.sv */
// Concurrent checks on the ports of the capability-two and PM header register bank.
`timescale 1ns/100ps
`default_nettype none
module cap2_pm_assertions #(
	parameter bit downstream_port = 1'b1
) (
	input wire logic                    clk,
	input wire logic                    rst_n,
	input wire logic [11:0]             addr,
	input wire logic [31:0]             wdata,
	input wire logic                    wr,
	input wire logic                    rd,
	input wire logic [31:0]             rdata,
	input wire logic                    legacy_mode,
	input wire logic                    hot_reset,
	input wire logic                    link_unreliable,
	input wire cap2_pm_pkg::train_ctl_t train_ctl
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	hdr_const_a: assert property (rd && addr == 12'h0c0 |=> rdata[19:0] ==? 20'h3??01)
		else $error("pm header constant fields wrong");
	rsvd_zero_a: assert property (rd && addr inside {12'h064, 12'h068, 12'h06a, 12'h06c,
		12'h072, 12'h074, 12'h078, 12'h07a, 12'h0c8} |=> rdata == 32'h0)
		else $error("reserved word read not zero");
	idle_zero_a: assert property (!rd |=> rdata == 32'h0)
		else $error("read data not zero outside read answer");
	legacy_zero_a: assert property (legacy_mode ##1 legacy_mode && rd && addr == 12'h070
		|=> rdata == 32'h0)
		else $error("link control two not zero in legacy mode");
	force_hot_a: assert property (!hot_reset |=> !train_ctl.force_compliance)
		else $error("compliance forced without hot reset");
	down_ok_a: assert property (link_unreliable |=> train_ctl.autonomous_down_allowed)
		else $error("speed reduction blocked on unreliable link");
	disable_hold_a: assert property (wr && addr == 12'h070 && !legacy_mode && wdata[5]
		##1 !wr && !legacy_mode && !link_unreliable
		|=> !train_ctl.autonomous_up_allowed && !train_ctl.autonomous_down_allowed)
		else $error("speed change allowed while disabled");
	speed_cap_a: assert property (wr && addr == 12'h070 && !legacy_mode
		##1 !wr && !legacy_mode |=> train_ctl.compliance_speed == 4'($past(wdata, 2))
		&& train_ctl.advertise_speed_cap == (downstream_port ? 4'($past(wdata, 2)) : 4'h2))
		else $error("training speeds do not follow target speed");
endmodule : cap2_pm_assertions

bind cap2_pm_regs cap2_pm_assertions #(.downstream_port(downstream_port)) chk_i (.clk(clk),
	.rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.legacy_mode(legacy_mode), .hot_reset(hot_reset), .link_unreliable(link_unreliable),
	.train_ctl(train_ctl));
`default_nettype wire

/* cap2_pm_pkg.sv */
// Package with offsets, field layouts and reset values of the capability-two and PM header block.
package cap2_pm_pkg;

	// ------------------------------------------------------------
	// Register offsets (printed offsets are kept as indices)
	// ------------------------------------------------------------
	localparam logic [11:0] device_caps_two_idx        = 12'h064;
	localparam logic [11:0] device_control_two_idx     = 12'h068;
	localparam logic [11:0] device_status_two_idx      = 12'h06a;
	localparam logic [11:0] link_caps_two_idx          = 12'h06c;
	localparam logic [11:0] link_control_two_idx       = 12'h070;
	localparam logic [11:0] link_status_two_idx        = 12'h072;
	localparam logic [11:0] slot_caps_two_idx          = 12'h074;
	localparam logic [11:0] slot_control_two_idx       = 12'h078;
	localparam logic [11:0] slot_status_two_idx        = 12'h07a;
	localparam logic [11:0] power_mgmt_caps_header_idx = 12'h0c0;
	localparam logic [11:0] lock_control_idx           = 12'h0c8;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int target_speed_lsb           = 0;
	localparam int target_speed_msb           = 3;
	localparam int compliance_entry_pos       = 4;
	localparam int speed_change_disable_pos   = 5;
	localparam int capability_identifier_lsb  = 0;
	localparam int next_pointer_lsb           = 8;
	localparam int pm_version_lsb             = 16;
	localparam int pm_event_clock_pos         = 19;

	// ------------------------------------------------------------
	// Codes and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] speed_code_2g5        = 4'h1;
	localparam logic [3:0] speed_code_5g0        = 4'h2;
	localparam logic [3:0] target_speed_reset    = 4'h0;
	localparam logic       compliance_reset      = 1'h0;
	localparam logic       speed_disable_reset   = 1'h0;
	localparam logic [7:0] capability_identifier = 8'h01;
	localparam logic [7:0] next_ptr_upstream     = 8'h00;
	localparam logic [7:0] next_ptr_downstream   = 8'hd0;
	localparam logic [2:0] pm_version            = 3'h3;
	localparam logic       pm_event_clock        = 1'h0;

	// Link control two writable content.
	typedef struct packed {
		logic       speed_change_disable_bit;
		logic       compliance_entry_bit;
		logic [3:0] target_speed_field;
	} link_ctl_t;

	// Outputs toward the link training logic.
	typedef struct packed {
		logic [3:0] advertise_speed_cap;
		logic [3:0] compliance_speed;
		logic       force_compliance;
		logic       autonomous_up_allowed;
		logic       autonomous_down_allowed;
	} train_ctl_t;

endpackage : cap2_pm_pkg

/* cap2_pm_regs.sv */
// Register bank for capability-two words and the power management capability header.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Register bank
// ------------------------------------------------------------
// Overview of operation
// - Target speed code 1 is 2.5 Gbps, 2 is 5 Gbps; others reserved.
// - Downstream port caps advertised training speed by the target speed field.
// - Target speed field selects compliance speed on both port kinds.
// - Sticky compliance bit plus hot reset forces compliance at target speed.
// - In 1.1 mode speed, compliance and disable bits read zero, ignore writes.
// - Speed-change disable allows only speed reduction for unreliable links.
// - Capability identifier reads 0x1 and is read-only.
// - Upstream port next pointer defaults to 0x0, ending the list.
// - Downstream port next pointer defaults to 0xD0.
// - PM version field reads 0x3 and is read-only.
// - PM event clock flag reads zero and is read-only.
module cap2_pm_regs #(
	parameter bit downstream_port = 1'b1
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// Sticky reset: of the two resets only this one clears the compliance bit
	input  wire logic                       sticky_rst_n,
	// Register port
	input  wire logic [11:0]                addr,
	input  wire logic [31:0]                wdata,
	input  wire logic                       wr,
	input  wire logic                       rd,
	output var  logic [31:0]                rdata,
	// Mode and link status
	input  wire logic                       legacy_mode,
	input  wire logic                       lock_write_enable,
	input  wire logic                       hot_reset,
	input  wire logic                       link_unreliable,
	// Training controls
	output var  cap2_pm_pkg::train_ctl_t    train_ctl
);

	typedef struct packed {
		cap2_pm_pkg::link_ctl_t  lctl;
		logic [7:0]              next_ptr;
		logic [31:0]             rdata;
		cap2_pm_pkg::train_ctl_t train;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	function automatic logic [31:0] read_mux(input logic [11:0] a, input state_t s);
		logic [31:0] v;
		v = 32'h0000_0000;
		// Reserved words simply fall through to zero.
		case (a)
			cap2_pm_pkg::link_control_two_idx:
				v = {26'h0, s.lctl};
			cap2_pm_pkg::power_mgmt_caps_header_idx:
			begin
				v[cap2_pm_pkg::capability_identifier_lsb +: 8] =
					cap2_pm_pkg::capability_identifier;
				v[cap2_pm_pkg::next_pointer_lsb +: 8] = s.next_ptr;
				v[cap2_pm_pkg::pm_version_lsb +: 3]   = cap2_pm_pkg::pm_version;
				v[cap2_pm_pkg::pm_event_clock_pos]    = cap2_pm_pkg::pm_event_clock;
			end
			default:
				v = 32'h0000_0000;
		endcase
		return v;
	endfunction : read_mux

	localparam logic [7:0] next_ptr_default = downstream_port ?
		cap2_pm_pkg::next_ptr_downstream : cap2_pm_pkg::next_ptr_upstream;

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.rdata = rd ? read_mux(addr, state_r) : 32'h0000_0000;
		if (wr && addr == cap2_pm_pkg::link_control_two_idx && !legacy_mode)
		begin
			// No check on the code: unsupported values are software's fault.
			state_nxt.lctl.target_speed_field =
				wdata[cap2_pm_pkg::target_speed_msb:cap2_pm_pkg::target_speed_lsb];
			state_nxt.lctl.compliance_entry_bit =
				wdata[cap2_pm_pkg::compliance_entry_pos];
			state_nxt.lctl.speed_change_disable_bit =
				wdata[cap2_pm_pkg::speed_change_disable_pos];
		end
		if (wr && addr == cap2_pm_pkg::power_mgmt_caps_header_idx && lock_write_enable)
			state_nxt.next_ptr = wdata[cap2_pm_pkg::next_pointer_lsb +: 8];
		if (legacy_mode)
			state_nxt.lctl = '0;
		// The cap only matters downstream; upstream advertises freely.
		state_nxt.train.advertise_speed_cap = downstream_port ?
			state_nxt.lctl.target_speed_field : cap2_pm_pkg::speed_code_5g0;
		state_nxt.train.compliance_speed = state_nxt.lctl.target_speed_field;
		state_nxt.train.force_compliance =
			hot_reset && state_nxt.lctl.compliance_entry_bit;
		state_nxt.train.autonomous_up_allowed = !state_nxt.lctl.speed_change_disable_bit;
		state_nxt.train.autonomous_down_allowed =
			!state_nxt.lctl.speed_change_disable_bit || link_unreliable;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_r.lctl.target_speed_field       <= cap2_pm_pkg::target_speed_reset;
			state_r.lctl.speed_change_disable_bit <= cap2_pm_pkg::speed_disable_reset;
			state_r.next_ptr                      <= next_ptr_default;
			state_r.rdata                         <= 32'h0000_0000;
			state_r.train                         <= '0;
		end
		else
		begin
			state_r.lctl.target_speed_field       <= state_nxt.lctl.target_speed_field;
			state_r.lctl.speed_change_disable_bit <= state_nxt.lctl.speed_change_disable_bit;
			state_r.next_ptr                      <= state_nxt.next_ptr;
			state_r.rdata                         <= state_nxt.rdata;
			state_r.train                         <= state_nxt.train;
		end
		// The compliance bit survives an ordinary reset.
		if (!sticky_rst_n)
			state_r.lctl.compliance_entry_bit <= cap2_pm_pkg::compliance_reset;
		else
			state_r.lctl.compliance_entry_bit <= state_nxt.lctl.compliance_entry_bit;
	end

	assign rdata     = state_r.rdata;
	assign train_ctl = state_r.train;

endmodule : cap2_pm_regs
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench for the capability-two and PM header register bank.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic                    clk = 1'b0, rst_n = 1'b0, sticky_rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic                    legacy_mode = 1'b0, lock_write_enable = 1'b0, hot_reset = 1'b0;
	logic                    link_unreliable = 1'b0;
	logic [11:0]             addr = 12'h0;
	logic [31:0]             wdata = 32'h0;
	logic [31:0]             rdata;
	cap2_pm_pkg::train_ctl_t train_ctl;
	int                      mismatches = 0, n_tests = 0, cyc = 0;
	logic [11:0]             ta [11] = '{12'h070, 12'h0c0, 12'h064, 12'h068, 12'h06a, 12'h06c,
		12'h072, 12'h074, 12'h078, 12'h07a, 12'h0c8};
	logic [31:0]             te [11] = '{0: 32'h21, 1: 32'h0003d001, default: 32'h0};
	always #50 clk = ~clk;
	cap2_pm_regs #(.downstream_port(1'b1)) DUT (.clk(clk), .rst_n(rst_n),
		.sticky_rst_n(sticky_rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .legacy_mode(legacy_mode), .lock_write_enable(lock_write_enable),
		.hot_reset(hot_reset), .link_unreliable(link_unreliable), .train_ctl(train_ctl));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			mismatches++;
		end
	endtask : chk
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
		@(posedge clk);
	endtask : rd_chk
	task automatic t_map;
		rd_chk(12'h070, 32'h0);
		for (int i = 0; i < 11; i++)
		begin
			wr_reg(ta[i], 32'hffffffe1);
			rd_chk(ta[i], te[i]);
		end
		lock_write_enable <= 1'b1;
		wr_reg(12'h0c0, 32'h00004400);
		lock_write_enable <= 1'b0;
		rd_chk(12'h0c0, 32'h00034401);
		legacy_mode <= 1'b1;
		@(posedge clk);
		wr_reg(12'h070, 32'h00000012);
		rd_chk(12'h070, 32'h0);
		legacy_mode <= 1'b0;
	endtask : t_map
	task automatic t_speed;
		for (logic [3:0] s = 4'h1; s < 4'h3; s++)
		begin
			wr_reg(12'h070, {28'h1, s});
			@(posedge clk);
			#1 chk({24'h0, train_ctl.advertise_speed_cap, train_ctl.compliance_speed}, {24'h0, s, s});
			@(posedge clk);
		end
		rd_chk(12'h070, 32'h12);
		hot_reset <= 1'b1;
		@(posedge clk);
		#1 chk({31'h0, train_ctl.force_compliance}, 32'h1);
		@(posedge clk);
		hot_reset <= 1'b0;
		wr_reg(12'h070, 32'h00000032);
		@(posedge clk);
		#1 chk({30'h0, train_ctl.autonomous_up_allowed, train_ctl.autonomous_down_allowed}, 32'h0);
		@(posedge clk);
		link_unreliable <= 1'b1;
		@(posedge clk);
		#1 chk({30'h0, train_ctl.autonomous_up_allowed, train_ctl.autonomous_down_allowed}, 32'h1);
		@(posedge clk);
		link_unreliable <= 1'b0;
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_chk(12'h070, 32'h10);
	endtask : t_speed
	task automatic stop_test;
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		sticky_rst_n <= 1'b1;
		@(posedge clk);
		t_map();
		t_speed();
		stop_test();
	end
	// The whole run needs about seventy cycles, so five hundred means a hang.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 500)
		begin
			mismatches++;
			stop_test();
		end
	end
endmodule : tb_top
`default_nettype wire
